// [verilog/flash_cmd_host.sv]
// Host controller that issues flash command sequences over the pins
// Contract
// - Array read is one plain read cycle with no unlock writes.
// - Reset is F0 written to any address; used after timeout flag.
// - Identification entry is three writes, then reads of ID locations.
// - Query entry is 98 to AA, from read array or identification.
// - Program: AA, 55, A0, then value at program location.
// - Buffer load: unlock, 25 at sector, count-1, then each word.
// - Count field is the number of buffer words minus one.
// - All buffer words lie in the page of the start location.
// - Commit buffer with 29 written to the sector address.
// - Abort recovery is AA, 55, F0 to AAA, even in bypass.
// - Bypass: 20 enters; A0 program, 80/30 sector, 80/10 chip.
// - Bypass exit is 90 then 00 to any address.
// - Erase takes six writes, last 30 at sector or 10 at AAA.
// - Secured region entry ends 88; exit ends 90 then 00.
// - Every sequence cycle is a write unless marked as a read.
`timescale 1ns/1ps
module flash_cmd_host
    import flash_cmd_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Command port
    input wire logic req_valid,
    input wire cmd_req_t req,
    output logic req_ready,
    output logic resp_valid,
    output logic [7:0] resp_data,
    output logic resp_flag,
    output logic refused,
    // Flash pins
    output logic flash_we_n,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [15:0] upper_and_low_dq_out,
    output logic dq_oe,
    input wire logic [15:0] dq_in
);
    typedef enum logic [1:0] {M_ARRAY, M_IDENT, M_BYPASS, M_SECURE} mode_t;
    typedef enum logic [1:0] {X_IDLE, X_RUN, X_DONE} seq_t;

    seq_t st;
    mode_t mode;
    logic suspended;
    logic sector_erasing;
    logic busy_op;
    cmd_req_t cur;
    logic [2:0] idx;
    logic [2:0] len;
    logic start;
    logic done;
    logic [15:0] rdata;
    flash_pins_t pins;
    bus_cycle_t cyc;

    flash_bus_cycle flash_bus_cycle_i (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(start),
        .cyc(cyc),
        .done(done),
        .rdata(rdata),
        .pins(pins),
        .dq_in(dq_in)
    );

    assign flash_we_n = pins.we_n;
    assign flash_ce_n = pins.ce_n;
    assign flash_oe_n = pins.oe_n;
    assign flash_addr = pins.addr;
    assign upper_and_low_dq_out = pins.dq_out;
    assign dq_oe = pins.dq_oe;

    function automatic bus_cycle_t wr(input logic [ADDR_W-1:0] a,
                                      input logic [7:0] d);
        bus_cycle_t c;
        c.write = 1'b1;
        c.addr = a;
        c.data = d;
        return c;
    endfunction

    function automatic bus_cycle_t rd(input logic [ADDR_W-1:0] a);
        bus_cycle_t c;
        c.write = 1'b0;
        c.addr = a;
        c.data = 8'h00;
        return c;
    endfunction

    function automatic logic [ADDR_W-1:0] sector_of(
        input logic [ADDR_W-1:0] a);
        return a & SECTOR_MASK;
    endfunction

    function automatic logic [ADDR_W-1:0] page_of(
        input logic [ADDR_W-1:0] a);
        return a & PAGE_MASK;
    endfunction

    // Unlock prefix shared by most sequences
    function automatic bus_cycle_t unlock(input logic [2:0] i,
                                          input logic [ADDR_W-1:0] a3,
                                          input logic [7:0] d3);
        unique case (i)
            3'd0: return wr(ADDR_UNLOCK1, D_UNLOCK1);
            3'd1: return wr(ADDR_UNLOCK2, D_UNLOCK2);
            default: return wr(a3, d3);
        endcase
    endfunction

    // Whether a request is legal in the present mode
    function automatic logic allowed(input op_t op, input mode_t m,
                                     input logic susp, input logic serase,
                                     input logic busy);
        unique case (op)
            OP_CFI: return m == M_ARRAY || m == M_IDENT;
            OP_PROT_READ, OP_SECURE_READ:
                return m == M_IDENT;
            OP_BYPASS_PROGRAM, OP_BYPASS_SECTOR_ERASE,
            OP_BYPASS_CHIP_ERASE, OP_BYPASS_EXIT:
                return m == M_BYPASS;
            OP_SUSPEND: return busy && !susp && serase;
            OP_RESUME: return susp;
            OP_CHIP_ERASE, OP_SECTOR_ERASE: return !susp;
            OP_SECURE_EXIT: return m == M_SECURE;
            default: return 1'b1;
        endcase
    endfunction

    function automatic logic [2:0] seq_len(input op_t op);
        unique case (op)
            OP_READ, OP_RESET, OP_PROT_READ,
            OP_SECURE_READ, OP_CFI, OP_BUF_WORD, OP_BUF_COMMIT,
            OP_SUSPEND, OP_RESUME: return 3'd1;
            OP_BYPASS_PROGRAM, OP_BYPASS_SECTOR_ERASE,
            OP_BYPASS_CHIP_ERASE, OP_BYPASS_EXIT: return 3'd2;
            OP_ABORT_RESET, OP_BYPASS_ENTER, OP_SECURE_ENTER: return 3'd3;
            OP_BUF_START: return 3'd5;
            OP_PROGRAM, OP_IDENT_READ, OP_SECURE_EXIT: return 3'd4;
            default: return 3'd6;
        endcase
    endfunction

    // Cycle for step i of the current command
    always_comb
    begin
        cyc = wr(cur.addr, cur.data);
        unique case (cur.op)
            OP_READ: cyc = rd(cur.addr);
            OP_RESET: cyc = wr(cur.addr, D_RESET);
            OP_IDENT_READ:
                cyc = (idx < 3'd3) ? unlock(idx, ADDR_UNLOCK1, D_IDENT)
                    : rd(cur.addr);
            OP_PROT_READ: cyc = rd(sector_of(cur.addr) | OFS_PROT);
            OP_SECURE_READ: cyc = rd(OFS_SECURE);
            OP_CFI: cyc = wr(ADDR_CFI, D_CFI);
            OP_PROGRAM:
                cyc = (idx < 3'd3) ? unlock(idx, ADDR_UNLOCK1, D_PROGRAM)
                    : wr(cur.addr, cur.data);
            OP_BUF_START:
                if (idx < 3'd3)
                    cyc = unlock(idx, sector_of(cur.addr), D_BUF_LOAD);
                else if (idx == 3'd3)
                    cyc = wr(sector_of(cur.addr),
                             {2'b00, cur.count - 6'd1});
                else
                    cyc = wr(cur.addr, cur.data);
            OP_BUF_WORD: cyc = wr(cur.addr, cur.data);
            OP_BUF_COMMIT:
                cyc = wr(sector_of(cur.addr), D_BUF_COMMIT);
            OP_ABORT_RESET: cyc = unlock(idx, ADDR_UNLOCK1, D_RESET);
            OP_BYPASS_ENTER: cyc = unlock(idx, ADDR_UNLOCK1, D_BYPASS);
            OP_BYPASS_PROGRAM:
                cyc = (idx == 3'd0) ? wr(ADDR_ZERO, D_PROGRAM)
                    : wr(cur.addr, cur.data);
            OP_BYPASS_SECTOR_ERASE:
                cyc = (idx == 3'd0) ? wr(ADDR_ZERO, D_ERASE)
                    : wr(sector_of(cur.addr), D_SECTOR_ERASE);
            OP_BYPASS_CHIP_ERASE:
                cyc = (idx == 3'd0) ? wr(ADDR_ZERO, D_ERASE)
                    : wr(ADDR_ZERO, D_CHIP_ERASE);
            OP_BYPASS_EXIT:
                cyc = wr(ADDR_ZERO, (idx == 3'd0) ? D_IDENT : D_EXIT);
            OP_CHIP_ERASE, OP_SECTOR_ERASE:
                if (idx < 3'd3)
                    cyc = unlock(idx, ADDR_UNLOCK1, D_ERASE);
                else if (idx < 3'd5)
                    cyc = unlock(idx - 3'd3, ADDR_UNLOCK1, D_ERASE);
                else if (cur.op == OP_SECTOR_ERASE)
                    cyc = wr(sector_of(cur.addr), D_SECTOR_ERASE);
                else
                    cyc = wr(ADDR_UNLOCK1, D_CHIP_ERASE);
            OP_SUSPEND: cyc = wr(ADDR_ZERO, D_SUSPEND);
            OP_RESUME: cyc = wr(ADDR_ZERO, D_RESUME);
            OP_SECURE_ENTER: cyc = unlock(idx, ADDR_UNLOCK1, D_SECURE);
            OP_SECURE_EXIT:
                cyc = (idx < 3'd3) ? unlock(idx, ADDR_UNLOCK1, D_IDENT)
                    : wr(ADDR_ZERO, D_EXIT);
            default: cyc = wr(cur.addr, cur.data);
        endcase
    end

    // Sequencer
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st <= X_IDLE;
            cur <= '0;
            idx <= 3'd0;
            len <= 3'd0;
            start <= 1'b0;
            req_ready <= 1'b0;
            refused <= 1'b0;
        end
        else
        begin
            start <= 1'b0;
            refused <= 1'b0;
            req_ready <= 1'b0;
            unique case (st)
                X_IDLE:
                    if (req_valid && !req_ready)
                    begin
                        req_ready <= 1'b1;
                        if (allowed(req.op, mode, suspended,
                                    sector_erasing, busy_op)
                            && (req.op != OP_BUF_WORD
                                || page_of(req.addr) == page_of(cur.addr)))
                        begin
                            cur <= req;
                            idx <= 3'd0;
                            len <= seq_len(req.op);
                            start <= 1'b1;
                            st <= X_RUN;
                        end
                        else
                            refused <= 1'b1;
                    end
                X_RUN:
                    if (done)
                    begin
                        if (idx + 3'd1 < len)
                        begin
                            idx <= idx + 3'd1;
                            start <= 1'b1;
                        end
                        else
                            st <= X_DONE;
                    end
                X_DONE:
                    st <= X_IDLE;
            endcase
        end
    end

    // Answer with read data and the flag bit for the read kind
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            resp_valid <= 1'b0;
            resp_data <= 8'h00;
            resp_flag <= 1'b0;
        end
        else
        begin
            resp_valid <= st == X_DONE;
            if (st == X_DONE)
            begin
                resp_data <= rdata[7:0];
                unique case (cur.op)
                    OP_PROT_READ:
                        resp_flag <= rdata[7:0] == PROT_YES;
                    OP_SECURE_READ:
                        resp_flag <= rdata[SERIAL_BIT];
                    default:
                        resp_flag <= rdata[TIMEOUT_BIT];
                endcase
            end
        end
    end

    // Tracked device mode after each completed sequence
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            mode <= M_ARRAY;
            suspended <= 1'b0;
            sector_erasing <= 1'b0;
            busy_op <= 1'b0;
        end
        else if (st == X_DONE)
        begin
            unique case (cur.op)
                OP_RESET, OP_ABORT_RESET, OP_BYPASS_EXIT, OP_SECURE_EXIT:
                    mode <= M_ARRAY;
                OP_IDENT_READ, OP_PROT_READ, OP_SECURE_READ: mode <= M_IDENT;
                OP_BYPASS_ENTER: mode <= M_BYPASS;
                OP_SECURE_ENTER: mode <= M_SECURE;
                OP_SECTOR_ERASE, OP_BYPASS_SECTOR_ERASE:
                begin
                    busy_op <= 1'b1;
                    sector_erasing <= 1'b1;
                end
                OP_CHIP_ERASE, OP_BYPASS_CHIP_ERASE:
                begin
                    busy_op <= 1'b1;
                    sector_erasing <= 1'b0;
                end
                OP_SUSPEND: suspended <= 1'b1;
                OP_RESUME: suspended <= 1'b0;
                default:
                    mode <= mode;
            endcase
            if (cur.op == OP_RESET)
            begin
                busy_op <= 1'b0;
                suspended <= 1'b0;
                sector_erasing <= 1'b0;
            end
        end
    end
endmodule // flash_cmd_host

// [inc/flash_cmd_pkg.sv]
// Package with command codes, addresses, timing and carrier types
package flash_cmd_pkg;
    localparam int ADDR_W = 27;
    localparam int DATA_W = 8;
    localparam int CLK_MHZ = 20;
    // Bus timing in nanoseconds
    localparam int T_SETUP_NS = 50;
    localparam int T_PULSE_NS = 70;
    localparam int T_HOLD_NS = 50;
    localparam int T_READ_NS = 110;
    localparam int CYC_SETUP = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_PULSE = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_HOLD = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_READ = (T_READ_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 4;
    // Unlock addresses and command codes
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 27'h0000AAA;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 27'h0000555;
    localparam logic [ADDR_W-1:0] ADDR_CFI = 27'h00000AA;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 27'h0000000;
    localparam logic [ADDR_W-1:0] OFS_PROT = 27'h0000004;
    localparam logic [ADDR_W-1:0] OFS_SECURE = 27'h0000006;
    localparam logic [ADDR_W-1:0] SECTOR_MASK = 27'h7FF0000;
    // Write buffer page span; plain default, widen to suit the part
    localparam logic [ADDR_W-1:0] PAGE_MASK = 27'h7FFFFE0;
    localparam logic [7:0] D_UNLOCK1 = 8'hAA;
    localparam logic [7:0] D_UNLOCK2 = 8'h55;
    localparam logic [7:0] D_RESET = 8'hF0;
    localparam logic [7:0] D_IDENT = 8'h90;
    localparam logic [7:0] D_CFI = 8'h98;
    localparam logic [7:0] D_PROGRAM = 8'hA0;
    localparam logic [7:0] D_BUF_LOAD = 8'h25;
    localparam logic [7:0] D_BUF_COMMIT = 8'h29;
    localparam logic [7:0] D_BYPASS = 8'h20;
    localparam logic [7:0] D_ERASE = 8'h80;
    localparam logic [7:0] D_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] D_CHIP_ERASE = 8'h10;
    localparam logic [7:0] D_SUSPEND = 8'hB0;
    localparam logic [7:0] D_RESUME = 8'h30;
    localparam logic [7:0] D_SECURE = 8'h88;
    localparam logic [7:0] D_EXIT = 8'h00;
    localparam int TIMEOUT_BIT = 5;
    localparam int SERIAL_BIT = 7;
    localparam logic [7:0] PROT_YES = 8'h01;

    typedef enum logic [4:0] {
        OP_READ, OP_RESET, OP_IDENT_READ, OP_PROT_READ, OP_SECURE_READ,
        OP_CFI, OP_PROGRAM, OP_BUF_START, OP_BUF_WORD, OP_BUF_COMMIT,
        OP_ABORT_RESET, OP_BYPASS_ENTER, OP_BYPASS_PROGRAM,
        OP_BYPASS_SECTOR_ERASE, OP_BYPASS_CHIP_ERASE, OP_BYPASS_EXIT,
        OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME,
        OP_SECURE_ENTER, OP_SECURE_EXIT
    } op_t;

    typedef struct packed {
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
        logic [5:0] count;
    } cmd_req_t;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } bus_cycle_t;

    typedef struct packed {
        logic we_n;
        logic ce_n;
        logic oe_n;
        logic [ADDR_W-1:0] addr;
        logic [15:0] dq_out;
        logic dq_oe;
    } flash_pins_t;
endpackage

// [verilog/flash_bus_cycle.sv]
// One write or read cycle on the parallel flash pins
`timescale 1ns/1ps
module flash_bus_cycle
    import flash_cmd_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Cycle request
    input wire logic start,
    input wire bus_cycle_t cyc,
    output logic done,
    output logic [15:0] rdata,
    // Pins
    output flash_pins_t pins,
    input wire logic [15:0] dq_in
);
    typedef enum logic [1:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD} ph_t;
    ph_t ph;
    logic [CNT_W-1:0] cnt;
    logic is_write;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;

    always_ff @(posedge mclk)
    begin
        dq_s1 <= dq_in;
        dq_s2 <= dq_s1;
    end

    // Address settles before strobes fall; data is held past the rising
    // edge so the device latches it on whichever strobe rises first
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ph <= S_IDLE;
            cnt <= '0;
            done <= 1'b0;
            is_write <= 1'b0;
            rdata <= 16'h0000;
            pins <= '{we_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1,
                      addr: '0, dq_out: 16'h0000, dq_oe: 1'b0};
        end
        else
        begin
            done <= 1'b0;
            unique case (ph)
                S_IDLE:
                    if (start)
                    begin
                        is_write <= cyc.write;
                        pins.addr <= cyc.addr;
                        pins.dq_out <= {8'h00, cyc.data};
                        pins.dq_oe <= cyc.write;
                        cnt <= CNT_W'(CYC_SETUP);
                        ph <= S_SETUP;
                    end
                S_SETUP:
                    if (cnt > CNT_W'(1))
                        cnt <= cnt - CNT_W'(1);
                    else
                    begin
                        pins.ce_n <= 1'b0;
                        pins.we_n <= ~is_write;
                        pins.oe_n <= is_write;
                        cnt <= is_write ? CNT_W'(CYC_PULSE)
                                        : CNT_W'(CYC_READ + 2);
                        ph <= S_PULSE;
                    end
                S_PULSE:
                    if (cnt > CNT_W'(1))
                        cnt <= cnt - CNT_W'(1);
                    else
                    begin
                        pins.we_n <= 1'b1;
                        pins.ce_n <= 1'b1;
                        pins.oe_n <= 1'b1;
                        rdata <= dq_s2;
                        cnt <= CNT_W'(CYC_HOLD);
                        ph <= S_HOLD;
                    end
                S_HOLD:
                    if (cnt > CNT_W'(1))
                        cnt <= cnt - CNT_W'(1);
                    else
                    begin
                        pins.dq_oe <= 1'b0;
                        done <= 1'b1;
                        ph <= S_IDLE;
                    end
            endcase
        end
    end
endmodule // flash_bus_cycle

// [tb/flash_cmd_host_chk.sv]
// Pin-level assertions for the flash command host
`timescale 1ns/1ps
module flash_cmd_host_chk
    import flash_cmd_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Command handshake
    input wire logic req_ready,
    input wire logic refused,
    // Flash pins
    input wire logic flash_we_n,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [15:0] upper_and_low_dq_out,
    input wire logic dq_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_upper_byte_zero: assert property (
        dq_oe |-> upper_and_low_dq_out[15:8] == 8'h00)
        else $error("upper data byte not zero");
    a_strobe_excl: assert property (
        flash_we_n || flash_oe_n)
        else $error("write and read strobes low together");
    a_write_pulse: assert property (
        $fell(flash_we_n) |-> !flash_ce_n && dq_oe ##1 !flash_we_n
        ##1 flash_we_n && flash_ce_n)
        else $error("write pulse shape wrong");
    a_addr_steady: assert property (
        !flash_ce_n |-> $stable(flash_addr))
        else $error("address moved while selected");
    a_data_held: assert property (
        $rose(flash_we_n) |-> dq_oe && $stable(upper_and_low_dq_out)
        ##1 !dq_oe)
        else $error("write data not held over strobe rise");
    a_read_pulse: assert property (
        $fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n && !dq_oe)[*5]
        ##1 flash_oe_n)
        else $error("read pulse shape wrong");
    a_refuse_ready: assert property (
        refused |-> req_ready)
        else $error("refusal without ready");
    a_refuse_idle: assert property (
        refused |-> flash_ce_n[*3])
        else $error("bus cycle after refusal");
    a_idle_strobes: assert property (
        flash_ce_n |-> flash_we_n && flash_oe_n)
        else $error("strobe low while deselected");
endmodule // flash_cmd_host_chk

bind flash_cmd_host flash_cmd_host_chk flash_cmd_host_chk_i (.mclk, .sys_rst,
    .req_ready, .refused, .flash_we_n, .flash_ce_n, .flash_oe_n, .flash_addr,
    .upper_and_low_dq_out, .dq_oe);

// [tb/flash_dev_model.sv]
// Behavioural flash device that logs writes and answers reads
`timescale 1ns/1ps
module flash_dev_model
    import flash_cmd_pkg::*;
#(
    parameter logic [10:0] PROT_SECT = 11'h003,
    parameter logic SERIALIZED = 1'b1
)
(
    // Pins from the host
    input wire logic we_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    // Bus level seen by the host
    output logic [15:0] dq_in
);
    logic [ADDR_W-1:0] lat_addr;
    logic [ADDR_W+7:0] wlog[$];
    logic [1:0] step = 2'd0;
    logic ident = 1'b0;
    logic [15:0] rd;
    logic [15:0] last = 16'h0000;
    wire strobe_n = we_n | ce_n;
    wire u1 = lat_addr[15:0] == ADDR_UNLOCK1[15:0];
    wire u2 = lat_addr[15:0] == ADDR_UNLOCK2[15:0];

    always @(negedge strobe_n)
        lat_addr = addr;
    always @(posedge strobe_n)
    begin
        if (dq_oe === 1'b1)
        begin
            wlog.push_back({lat_addr, dq_out[7:0]});
            if (step == 2'd2 && dq_out[7:0] == D_IDENT && u1)
                ident = 1'b1;
            else if (dq_out[7:0] == D_RESET || dq_out[7:0] == D_EXIT)
                ident = 1'b0;
            if (step == 2'd0 && dq_out[7:0] == D_UNLOCK1 && u1)
                step = 2'd1;
            else if (step == 2'd1 && dq_out[7:0] == D_UNLOCK2 && u2)
                step = 2'd2;
            else
                step = 2'd0;
        end
    end
    always @*
    begin
        if (ident && addr[7:0] == OFS_PROT[7:0])
            rd = {15'h0000, addr[26:16] == PROT_SECT};
        else if (ident && addr[7:0] == OFS_SECURE[7:0])
            rd = {8'h00, SERIALIZED, 7'h00};
        else
            rd = {8'h00, addr[7:0] ^ 8'h5A};
    end
    // Released bus shows the inverse of the last driven value
    always @(ce_n, oe_n, rd)
        if (!ce_n && !oe_n)
            last = rd;
    assign dq_in = dq_oe ? dq_out : (!ce_n && !oe_n) ? rd : ~last;
endmodule // flash_dev_model

// [tb/flash_cmd_host_test.sv]
// Self-checking testbench for the flash command host
`timescale 1ns/1ps
module flash_cmd_host_test
    import flash_cmd_pkg::*;
;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    cmd_req_t req = '0;
    logic req_ready, resp_valid, resp_flag, refused;
    logic [7:0] resp_data;
    logic flash_we_n, flash_ce_n, flash_oe_n, dq_oe;
    logic [ADDR_W-1:0] flash_addr;
    logic [15:0] upper_and_low_dq_out, dq_in;
    logic [34:0] ew[$];
    int fails = 0;
    int check_count = 0;

    always #25 mclk = ~mclk;

    flash_cmd_host flash_cmd_host_i (.mclk, .sys_rst, .req_valid, .req,
        .req_ready, .resp_valid, .resp_data, .resp_flag, .refused,
        .flash_we_n, .flash_ce_n, .flash_oe_n, .flash_addr,
        .upper_and_low_dq_out, .dq_oe, .dq_in);
    flash_dev_model flash_dev_model_i (.we_n(flash_we_n), .ce_n(flash_ce_n),
        .oe_n(flash_oe_n), .addr(flash_addr), .dq_out(upper_and_low_dq_out),
        .dq_oe, .dq_in);

    task automatic tally_and_finish;
        if (fails == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic w(input logic [26:0] a, input logic [7:0] d);
        ew.push_back({a, d});
    endtask

    task automatic ul;
        w(ADDR_UNLOCK1, D_UNLOCK1);
        w(ADDR_UNLOCK2, D_UNLOCK2);
    endtask

    // Issue one request, then compare refusal and the logged writes
    task automatic op(input op_t o, input logic [26:0] a, input logic r,
        input logic [7:0] d = 8'h00, input logic [5:0] c = 6'h00);
        int n;
        req = '{o, a, d, c};
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 50)
        begin
            @(negedge mclk);
            n++;
        end
        req_valid = 1'b0;
        chk("refused", refused, r);
        n = 0;
        while (!r && resp_valid !== 1'b1 && n < 200)
        begin
            @(negedge mclk);
            n++;
        end
        chk("done", resp_valid, !r);
        chk("writes", flash_dev_model_i.wlog.size(), ew.size());
        foreach (ew[i])
            chk("write", flash_dev_model_i.wlog[i], ew[i]);
        ew = {};
        flash_dev_model_i.wlog = {};
        @(negedge mclk);
    endtask

    task automatic t_read;
        op(OP_READ, 27'h0012325, 1'b0);
        chk("rdata", resp_data, 8'h7F);
        chk("flag", resp_flag, 1'b1);
    endtask

    task automatic t_ident;
        op(OP_PROT_READ, 27'h0030004, 1'b1);
        ul;
        w(ADDR_UNLOCK1, D_IDENT);
        op(OP_IDENT_READ, ADDR_ZERO, 1'b0);
        chk("rdata", resp_data, 8'h5A);
        op(OP_PROT_READ, 27'h0030004, 1'b0);
        chk("prot", resp_data, PROT_YES);
        chk("pflag", resp_flag, 1'b1);
        op(OP_PROT_READ, 27'h0020004, 1'b0);
        chk("unprot", resp_data, 8'h00);
        chk("uflag", resp_flag, 1'b0);
        op(OP_SECURE_READ, OFS_SECURE, 1'b0);
        chk("sflag", resp_flag, 1'b1);
        w(ADDR_CFI, D_CFI);
        op(OP_CFI, ADDR_CFI, 1'b0);
        w(ADDR_ZERO, D_RESET);
        op(OP_RESET, ADDR_ZERO, 1'b0);
        op(OP_PROT_READ, 27'h0030004, 1'b1);
    endtask

    task automatic t_prog_buf;
        ul;
        w(ADDR_UNLOCK1, D_PROGRAM);
        w(27'h0030010, 8'h3C);
        op(OP_PROGRAM, 27'h0030010, 1'b0, 8'h3C);
        ul;
        w(27'h0050000, D_BUF_LOAD);
        w(27'h0050000, 8'h01);
        w(27'h0050020, 8'h11);
        op(OP_BUF_START, 27'h0050020, 1'b0, 8'h11, 6'd2);
        w(27'h0050021, 8'h22);
        op(OP_BUF_WORD, 27'h0050021, 1'b0, 8'h22, 6'd2);
        op(OP_BUF_WORD, 27'h0050060, 1'b1, 8'h33, 6'd2);
        w(27'h0050000, D_BUF_COMMIT);
        op(OP_BUF_COMMIT, 27'h0050000, 1'b0);
        ul;
        w(ADDR_UNLOCK1, D_RESET);
        op(OP_ABORT_RESET, ADDR_ZERO, 1'b0);
    endtask

    task automatic er;
        ul;
        w(ADDR_UNLOCK1, D_ERASE);
        ul;
    endtask

    task automatic t_erase;
        er;
        w(27'h0070000, D_SECTOR_ERASE);
        op(OP_SECTOR_ERASE, 27'h0070000, 1'b0);
        w(ADDR_ZERO, D_SUSPEND);
        op(OP_SUSPEND, ADDR_ZERO, 1'b0);
        ul;
        w(ADDR_UNLOCK1, D_PROGRAM);
        w(27'h0080000, 8'h5A);
        op(OP_PROGRAM, 27'h0080000, 1'b0, 8'h5A);
        op(OP_CHIP_ERASE, ADDR_ZERO, 1'b1);
        w(ADDR_ZERO, D_RESUME);
        op(OP_RESUME, ADDR_ZERO, 1'b0);
        op(OP_RESUME, ADDR_ZERO, 1'b1);
        w(ADDR_ZERO, D_RESET);
        op(OP_RESET, ADDR_ZERO, 1'b0);
        er;
        w(ADDR_UNLOCK1, D_CHIP_ERASE);
        op(OP_CHIP_ERASE, ADDR_ZERO, 1'b0);
        op(OP_SUSPEND, ADDR_ZERO, 1'b1);
        w(ADDR_ZERO, D_RESET);
        op(OP_RESET, ADDR_ZERO, 1'b0);
    endtask

    task automatic t_bypass;
        op(OP_BYPASS_PROGRAM, 27'h0060004, 1'b1, 8'h77);
        ul;
        w(ADDR_UNLOCK1, D_BYPASS);
        op(OP_BYPASS_ENTER, ADDR_ZERO, 1'b0);
        op(OP_CFI, ADDR_CFI, 1'b1);
        w(ADDR_ZERO, D_PROGRAM);
        w(27'h0060004, 8'h77);
        op(OP_BYPASS_PROGRAM, 27'h0060004, 1'b0, 8'h77);
        w(ADDR_ZERO, D_ERASE);
        w(27'h0070000, D_SECTOR_ERASE);
        op(OP_BYPASS_SECTOR_ERASE, 27'h0070000, 1'b0);
        w(ADDR_ZERO, D_ERASE);
        w(ADDR_ZERO, D_CHIP_ERASE);
        op(OP_BYPASS_CHIP_ERASE, ADDR_ZERO, 1'b0);
        w(ADDR_ZERO, D_IDENT);
        w(ADDR_ZERO, D_EXIT);
        op(OP_BYPASS_EXIT, ADDR_ZERO, 1'b0);
        op(OP_BYPASS_PROGRAM, 27'h0060004, 1'b1, 8'h77);
    endtask

    task automatic t_secure;
        ul;
        w(ADDR_UNLOCK1, D_SECURE);
        op(OP_SECURE_ENTER, ADDR_ZERO, 1'b0);
        ul;
        w(ADDR_UNLOCK1, D_IDENT);
        w(ADDR_ZERO, D_EXIT);
        op(OP_SECURE_EXIT, ADDR_ZERO, 1'b0);
    endtask

    initial
    begin
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        t_read;
        t_ident;
        t_prog_buf;
        t_erase;
        t_bypass;
        t_secure;
        t_read;
        tally_and_finish;
    end

    initial
    begin
        #1000000;
        fails++;
        tally_and_finish;
    end
endmodule // flash_cmd_host_test
